// >>> common/iglu_pkg.sv
// Constants and types shared by the card decode and interrupt glue.
// Functional notes
// (RL1) The card answers only inside an eight byte I/O block at its base.
// (RL2) Address bits 15..8 match the high bank, bits 7..3 the low bank.
// (RL3) Offsets 0..3 reach the serial controller: A data, A control, B data, B control.
// (RL4) Offset 4 is the communications register, offset 5 the configuration register.
// (RL5) Offsets 6 and 7 are reserved, with no register behind them.
// (RL6) Configuration bits 5 and 4 pick the interrupt source: terminal count, test, controller.
// (RL7) With terminal count selected, a host terminal count pulse raises the interrupt.
// (RL8) The terminal count interrupt only works in shared interrupt mode.
// (RL9) In shared mode the line is driven only while an interrupt is pending.
// (RL10) In non-shared mode the line is driven all the time.
// (RL11) The interrupt goes to exactly one of eleven levels: 2-7, 10-12, 14-15.
// (RL12) Controller interrupt causes are enabled inside the controller and reach the card as one line.
// (RL13) A read of channel B control returns the controller's vector to the host.
// (RL14) Software resets the highest interrupt under service by writing 0x38 to the controller.
// (RL15) Software may send a 0x20 end of interrupt to the slave and then the master controller.
// (RL16) The request stays up until software clears its source, then drops within one cycle.
package iglu_pkg;
    // Offsets inside the eight byte block.
    localparam logic [2:0] OFF_DATA_A = 3'h0;
    localparam logic [2:0] OFF_CTRL_A = 3'h1;
    localparam logic [2:0] OFF_DATA_B = 3'h2;
    localparam logic [2:0] OFF_CTRL_B = 3'h3;
    localparam logic [2:0] OFF_COMM = 3'h4;
    localparam logic [2:0] OFF_CONFIG = 3'h5;
    localparam logic [2:0] OFF_RSVD_6 = 3'h6;
    localparam logic [2:0] OFF_RSVD_7 = 3'h7;

    // Address field positions.
    localparam int ADDR_HI_LSB = 8;
    localparam int ADDR_LO_LSB = 3;
    localparam int LO_BANK_USED = 5;

    // Configuration register fields and reset values.
    localparam int CFG_SRC_LSB = 4;
    localparam int CFG_PEND_BIT = 7;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] COMM_RESET = 8'h00;
    localparam logic [7:0] RSVD_READ = 8'h00;

    // Number of selectable host interrupt levels.
    localparam int NUM_LOW_LEVELS = 6;
    localparam int NUM_HIGH_LEVELS = 5;
    localparam int NUM_LEVELS = 11;

    // Interrupt source selection.
    typedef enum logic [1:0] {
        SRC_NONE = 2'b00,
        SRC_TC = 2'b01,
        SRC_TEST = 2'b10,
        SRC_SERIAL = 2'b11
    } iglu_src_t;

    // Host access sequencer.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SERIAL = 2'b01,
        ST_REPLY = 2'b10
    } iglu_state_t;
endpackage : iglu_pkg

// >>> hdl/iglu_decode.sv
// Base address compare and offset split for the eight byte block.
`timescale 1ns/10ps
`default_nettype none
module iglu_decode (
    // Host address.
    input wire logic [15:0] addr,
    // Switch banks.
    input wire logic [7:0] high_address_switch_bank,
    input wire logic [5:0] low_address_switch_bank,
    // Result.
    output logic hit,
    output logic [2:0] offset
);
    // The sixth low bank position is not compared at all.
    // (RL2) base compare
    always_comb
    begin
        hit = (addr[15:iglu_pkg::ADDR_HI_LSB] == high_address_switch_bank)
            && (addr[iglu_pkg::ADDR_HI_LSB-1:iglu_pkg::ADDR_LO_LSB]
                == low_address_switch_bank[iglu_pkg::LO_BANK_USED-1:0]);
        offset = addr[iglu_pkg::ADDR_LO_LSB-1:0];
    end
endmodule : iglu_decode
`default_nettype wire

// >>> hdl/iglu_top.sv
// Host bus glue: block decode, onboard registers and interrupt routing.
`timescale 1ns/10ps
`default_nettype none
module iglu_top (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Host I/O cycle, one-cycle strobes.
    input wire logic [15:0] io_addr,
    input wire logic io_rd_stb,
    input wire logic io_wr_stb,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic io_rdata_valid,
    // Host DMA terminal count.
    input wire logic dma_tc,
    // Switches and jumpers.
    input wire logic [7:0] high_address_switch_bank,
    input wire logic [5:0] low_address_switch_bank,
    input wire logic irq_share_jumper,
    input wire logic [5:0] low_irq_level_jumper,
    input wire logic [4:0] high_irq_level_jumper,
    // Serial controller port.
    output logic [1:0] scc_addr,
    output logic [7:0] scc_wdata,
    output logic scc_rd,
    output logic scc_wr,
    input wire logic [7:0] scc_rdata,
    input wire logic scc_irq,
    // Onboard register outputs.
    output logic [7:0] modem_comm,
    output logic [7:0] card_config,
    // Interrupt levels 2-7, 10-12, 14-15, lowest bit first.
    output logic [10:0] irq_level_out,
    output logic [10:0] irq_level_oe
);
    logic hit;
    logic [2:0] offset;
    iglu_pkg::iglu_state_t state;
    logic acc_write;
    logic [2:0] acc_off;
    logic tc_latch;
    logic irq_pend;
    logic next_pend;
    iglu_pkg::iglu_src_t src;
    logic [10:0] jumper_all;
    logic [10:0] level_sel;
    logic cfg_write;

    iglu_decode u_decode (
        .addr(io_addr),
        .high_address_switch_bank(high_address_switch_bank),
        .low_address_switch_bank(low_address_switch_bank),
        .hit(hit),
        .offset(offset)
    );

    // Source field of the configuration register.
    // (RL6) source select
    assign src = iglu_pkg::iglu_src_t'(card_config[iglu_pkg::CFG_SRC_LSB+:2]);
    assign cfg_write = (state == iglu_pkg::ST_IDLE) && io_wr_stb && hit
        && (offset == iglu_pkg::OFF_CONFIG);

    // Access sequencer: every read hit is answered two cycles after its strobe,
    // and strobes in the two cycles after a hit are ignored, so host software must pace accesses.
    // (RL1) block response
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state <= iglu_pkg::ST_IDLE;
            acc_write <= 1'b0;
            acc_off <= 3'h0;
        end
        else
        begin
            case (state)
                iglu_pkg::ST_IDLE:
                begin
                    if ((io_rd_stb || io_wr_stb) && hit)
                    begin
                        state <= iglu_pkg::ST_SERIAL;
                        acc_write <= io_wr_stb;
                        acc_off <= offset;
                    end
                end
                iglu_pkg::ST_SERIAL:
                begin
                    state <= iglu_pkg::ST_REPLY;
                end
                iglu_pkg::ST_REPLY:
                begin
                    state <= iglu_pkg::ST_IDLE;
                end
                default:
                begin
                    state <= iglu_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Controller strobes last the single cycle after the host strobe.
    // (RL3) controller ports
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            scc_addr <= 2'h0;
            scc_wdata <= 8'h00;
            scc_rd <= 1'b0;
            scc_wr <= 1'b0;
        end
        else
        begin
            scc_rd <= 1'b0;
            scc_wr <= 1'b0;
            if ((state == iglu_pkg::ST_IDLE) && hit && !offset[2])
            begin
                scc_addr <= offset[1:0];
                scc_wdata <= io_wdata;
                scc_rd <= io_rd_stb;
                scc_wr <= io_wr_stb;
            end
        end
    end

    // Onboard registers; reserved offsets take no write.
    // (RL4) onboard writes
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            modem_comm <= iglu_pkg::COMM_RESET;
            card_config <= iglu_pkg::CFG_RESET;
        end
        else if ((state == iglu_pkg::ST_IDLE) && io_wr_stb && hit)
        begin
            if (offset == iglu_pkg::OFF_COMM)
            begin
                modem_comm <= io_wdata;
            end
            else if (offset == iglu_pkg::OFF_CONFIG)
            begin
                card_config <= io_wdata;
            end
        end
    end

    // Read answer. The controller data, including the channel B vector,
    // is captured while its read strobe is high.
    // (RL13) vector passthrough
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            io_rdata <= 8'h00;
            io_rdata_valid <= 1'b0;
        end
        else
        begin
            io_rdata_valid <= 1'b0;
            if ((state == iglu_pkg::ST_SERIAL) && !acc_write)
            begin
                io_rdata_valid <= 1'b1;
                if (!acc_off[2])
                begin
                    io_rdata <= scc_rdata;
                end
                else if (acc_off == iglu_pkg::OFF_COMM)
                begin
                    io_rdata <= modem_comm;
                end
                else if (acc_off == iglu_pkg::OFF_CONFIG)
                begin
                    io_rdata <= card_config;
                    io_rdata[iglu_pkg::CFG_PEND_BIT] <= irq_pend;
                end
                else
                begin
                    // (RL5) reserved reads
                    io_rdata <= iglu_pkg::RSVD_READ;
                end
            end
        end
    end

    // Terminal count is sticky; any configuration write clears it, but a
    // pulse in the same cycle as that write still sets it.
    // (RL7) count latch
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            tc_latch <= 1'b0;
        end
        else if (dma_tc && (src == iglu_pkg::SRC_TC) && irq_share_jumper)
        begin
            // (RL8) shared only
            tc_latch <= 1'b1;
        end
        else if (cfg_write)
        begin
            tc_latch <= 1'b0;
        end
    end

    // Pending request follows the selected source. The controller merges
    // all of its own causes onto scc_irq, so it is taken as a level.
    // (RL12) controller line
    always_comb
    begin
        case (src)
            iglu_pkg::SRC_TC:
            begin
                next_pend = tc_latch && irq_share_jumper;
            end
            iglu_pkg::SRC_TEST:
            begin
                next_pend = 1'b1;
            end
            iglu_pkg::SRC_SERIAL:
            begin
                next_pend = scc_irq;
            end
            default:
            begin
                next_pend = 1'b0;
            end
        endcase
    end

    // (RL16) release timing
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            irq_pend <= 1'b0;
        end
        else
        begin
            irq_pend <= next_pend;
        end
    end

    // Only the lowest fitted jumper wins, so a doubled jumper can never
    // tie two host levels together.
    // (RL11) one level
    assign jumper_all = {high_irq_level_jumper, low_irq_level_jumper};
    assign level_sel = jumper_all & (~jumper_all + 11'h001);

    // Per level drivers, updated with the pending flag itself.
    genvar gi;
    generate
        for (gi = 0; gi < iglu_pkg::NUM_LEVELS; gi++)
        begin : g_level
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                begin
                    irq_level_out[gi] <= 1'b0;
                    irq_level_oe[gi] <= 1'b0;
                end
                else
                begin
                    irq_level_out[gi] <= level_sel[gi] && next_pend;
                    // (RL9) shared release
                    // (RL10) constant drive
                    irq_level_oe[gi] <= level_sel[gi]
                        && (next_pend || !irq_share_jumper);
                end
            end
        end
    endgenerate

    // Checks on the block's own behaviour.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_outside_silent: assert property ( // RL1
        (state == iglu_pkg::ST_IDLE) && io_rd_stb && !hit
        |-> ##2 !io_rdata_valid)
        else $error("Read outside block was answered.");

    a_read_two_cycles: assert property ( // RL1
        (state == iglu_pkg::ST_IDLE) && io_rd_stb && hit
        |-> !io_rdata_valid ##1 !io_rdata_valid ##1 io_rdata_valid)
        else $error("Read answer not two cycles after strobe.");

    a_serial_strobe: assert property ( // RL3
        (state == iglu_pkg::ST_IDLE) && hit && io_wr_stb && !offset[2]
        |=> scc_wr && (scc_addr == $past(offset[1:0]))
            && (scc_wdata == $past(io_wdata)))
        else $error("Controller write not issued at its port.");

    a_onboard_noserial: assert property ( // RL4
        (state == iglu_pkg::ST_IDLE) && hit && offset[2]
        |=> !scc_rd && !scc_wr)
        else $error("Onboard access reached the controller.");

    a_comm_written: assert property ( // RL4
        (state == iglu_pkg::ST_IDLE) && hit && io_wr_stb
        && (offset == iglu_pkg::OFF_COMM)
        |=> modem_comm == $past(io_wdata))
        else $error("Communications register missed a write.");

    a_reserved_zero: assert property ( // RL5
        (state == iglu_pkg::ST_IDLE) && hit && io_rd_stb && (offset[2:1] == 2'b11)
        |-> ##2 io_rdata == iglu_pkg::RSVD_READ)
        else $error("Reserved read returned nonzero data.");

    a_vector_return: assert property ( // RL13
        scc_rd |=> io_rdata_valid && (io_rdata == $past(scc_rdata)))
        else $error("Controller read data not returned.");

    a_tc_raise: assert property ( // RL7
        dma_tc && (src == iglu_pkg::SRC_TC) && irq_share_jumper
        |-> ##2 irq_pend)
        else $error("Terminal count did not raise interrupt.");

    a_tc_unshared: assert property ( // RL8
        !irq_share_jumper && (src == iglu_pkg::SRC_TC) |=> !irq_pend)
        else $error("Terminal count interrupt in non-shared mode.");

    a_shared_float: assert property ( // RL9
        irq_share_jumper && !next_pend |=> irq_level_oe == 11'h000)
        else $error("Shared line driven while idle.");

    a_unshared_drive: assert property ( // RL10
        !irq_share_jumper && (jumper_all != 11'h000)
        |=> $onehot(irq_level_oe))
        else $error("Non-shared line not driven.");

    a_single_level: assert property ( // RL11
        $onehot0(irq_level_oe) && $onehot0(irq_level_out))
        else $error("More than one level driven.");

    a_serial_release: assert property ( // RL16
        (src == iglu_pkg::SRC_SERIAL) && $fell(scc_irq) |-> ##1 !irq_pend)
        else $error("Request not released one cycle after source.");
endmodule : iglu_top
`default_nettype wire

// >>> sim/iglu_serial_model.sv
// Behavioural serial controller standing on the card's controller port.
`timescale 1ns/10ps
`default_nettype none
module iglu_serial_model #(
    parameter logic [7:0] VECTOR = 8'h5c // Arbitrary vector value.
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Port from the card.
    input wire logic [1:0] scc_addr,
    input wire logic [7:0] scc_wdata,
    input wire logic scc_rd,
    input wire logic scc_wr,
    output logic [7:0] scc_rdata,
    output logic scc_irq,
    // Bench command that raises an interrupt.
    input wire logic irq_raise
);
    logic [7:0] port_mem [4];
    logic [7:0] last_rd;

    // Port store, last read byte and the single pending interrupt line.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            port_mem <= '{default: 8'h00};
            last_rd <= 8'h00;
            scc_irq <= 1'b0;
        end
        else
        begin
            if (scc_wr)
                port_mem[scc_addr] <= scc_wdata;
            if (scc_rd)
                last_rd <= scc_rdata;
            if (irq_raise)
                scc_irq <= 1'b1;
            else if (scc_wr && scc_addr[0] && scc_wdata == 8'h38)
                scc_irq <= 1'b0;
        end
    end

    // Off a read the bus shows the inverse of the last byte, so a stale
    // sample by the card can never pass for a second read of that same byte.
    // vector on read
    always_comb
    begin
        if (!scc_rd)
            scc_rdata = ~last_rd;
        else if (scc_addr == 2'h3)
            scc_rdata = VECTOR;
        else
            scc_rdata = port_mem[scc_addr];
    end
endmodule : iglu_serial_model
`default_nettype wire

// >>> sim/tb_isa_card_decode_irq_glue.sv
// Self-checking bench for the card decode and interrupt glue.
`timescale 1ns/10ps
`default_nettype none
module tb_isa_card_decode_irq_glue;
    localparam logic [15:0] BASE = 16'h03a8;
    localparam logic [7:0] VEC = 8'h5c;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] io_addr = 16'h0000;
    logic io_rd_stb = 1'b0;
    logic io_wr_stb = 1'b0;
    logic [7:0] io_wdata = 8'h00;
    logic [7:0] io_rdata;
    logic io_rdata_valid;
    logic dma_tc = 1'b0;
    logic [7:0] hi_bank = 8'h03;
    logic [5:0] lo_bank = 6'h15;
    logic share = 1'b1;
    logic [5:0] lo_jmp = 6'h00;
    logic [4:0] hi_jmp = 5'h00;
    logic [1:0] scc_addr;
    logic [7:0] scc_wdata;
    logic scc_rd;
    logic scc_wr;
    logic [7:0] scc_rdata;
    logic scc_irq;
    logic [7:0] modem_comm;
    logic [7:0] card_config;
    logic [10:0] irq_out;
    logic [10:0] irq_oe;
    logic irq_raise = 1'b0;
    int n_errors = 0;
    int check_count = 0;

    // Free-running bus clock, 40 ns period.
    always #20 clk = ~clk;

    iglu_top DUT (.clk(clk), .rst(rst), .io_addr(io_addr),
        .io_rd_stb(io_rd_stb), .io_wr_stb(io_wr_stb), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
        .dma_tc(dma_tc), .high_address_switch_bank(hi_bank),
        .low_address_switch_bank(lo_bank), .irq_share_jumper(share),
        .low_irq_level_jumper(lo_jmp), .high_irq_level_jumper(hi_jmp),
        .scc_addr(scc_addr), .scc_wdata(scc_wdata), .scc_rd(scc_rd),
        .scc_wr(scc_wr), .scc_rdata(scc_rdata), .scc_irq(scc_irq),
        .modem_comm(modem_comm), .card_config(card_config),
        .irq_level_out(irq_out), .irq_level_oe(irq_oe));

    iglu_serial_model #(.VECTOR(VEC)) partner (.clk(clk), .rst(rst),
        .scc_addr(scc_addr), .scc_wdata(scc_wdata), .scc_rd(scc_rd),
        .scc_wr(scc_wr), .scc_rdata(scc_rdata), .scc_irq(scc_irq),
        .irq_raise(irq_raise));

    task automatic close_out();
        $display("errors %0d, checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : close_out

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    // Strobe for one cycle, then idle two; the next call's leading edge puts requests four apart.
    task automatic io_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        io_addr <= a;
        io_wdata <= d;
        io_wr_stb <= 1'b1;
        @(posedge clk);
        io_wr_stb <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : io_write

    // A read that must answer gives up after a bounded wait.
    task automatic io_read(input logic [15:0] a, input logic [7:0] exp,
        input logic want);
        logic got;
        got = 1'b0;
        @(posedge clk);
        io_addr <= a;
        io_rd_stb <= 1'b1;
        @(posedge clk);
        io_rd_stb <= 1'b0;
        for (int k = 0; k < 4 && !got; k++)
        begin
            @(posedge clk);
            #1;
            got = (io_rdata_valid === 1'b1);
        end
        if (want && !got)
        begin
            n_errors++;
            $display("[FAIL] %0t ns: no read answer", $time);
            close_out();
        end
        check({23'h0, got}, {23'h0, want});
        if (got)
            check({16'h0, io_rdata}, {16'h0, exp});
        // Hand back on an edge so the caller's next drive lands on one.
        @(posedge clk);
    endtask : io_read

    // Let the interrupt path settle, then compare level and enable.
    task automatic chk_irq(input logic [10:0] o, input logic [10:0] e);
        repeat (3) @(posedge clk);
        #1;
        check({1'b0, irq_out, 1'b0, irq_oe}, {1'b0, o, 1'b0, e});
        @(posedge clk);
    endtask : chk_irq

    task automatic pulse(input logic tc);
        @(posedge clk);
        dma_tc <= tc;
        irq_raise <= !tc;
        @(posedge clk);
        dma_tc <= 1'b0;
        irq_raise <= 1'b0;
    endtask : pulse

    // Main sequence; the last level left fitted is the top one.
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        io_read(BASE + 16'h5, 8'h00, 1'b1);
        io_write(BASE + 16'h4, 8'ha5);
        io_read(BASE + 16'h4, 8'ha5, 1'b1);
        check({16'h0, modem_comm}, 24'h0000a5);
        io_write(BASE + 16'h5, 8'h0c);
        io_read(BASE + 16'h5, 8'h0c, 1'b1);
        check({16'h0, card_config}, 24'h00000c);
        io_write(BASE + 16'h6, 8'hff);
        io_write(BASE + 16'h7, 8'hff);
        io_write(BASE + 16'h8, 8'h11);
        io_write(BASE - 16'h1, 8'h22);
        io_read(BASE + 16'h6, 8'h00, 1'b1);
        io_read(BASE + 16'h7, 8'h00, 1'b1);
        io_read(BASE + 16'h8, 8'h00, 1'b0);
        io_read(BASE - 16'h1, 8'h00, 1'b0);
        io_read(BASE + 16'h4, 8'ha5, 1'b1);
        lo_bank <= 6'h35;
        io_read(BASE + 16'h4, 8'ha5, 1'b1);
        hi_bank <= 8'h13;
        io_read(BASE + 16'h4, 8'h00, 1'b0);
        hi_bank <= 8'h03;
        for (int i = 0; i < 4; i++)
            io_write(BASE + 16'(i), 8'h40 + 8'(i));
        for (int i = 0; i < 3; i++)
            io_read(BASE + 16'(i), 8'h40 + 8'(i), 1'b1);
        io_read(BASE + 16'h3, VEC, 1'b1);
        io_write(BASE + 16'h5, 8'h20);
        for (int i = 0; i < 11; i++)
        begin
            lo_jmp <= (i < 6) ? 6'(1 << i) : 6'h00;
            hi_jmp <= (i >= 6) ? 5'(1 << (i - 6)) : 5'h00;
            chk_irq(11'(1 << i), 11'(1 << i));
        end
        io_read(BASE + 16'h5, 8'ha0, 1'b1);
        check({16'h0, card_config}, 24'h000020);
        io_write(BASE + 16'h5, 8'h00);
        chk_irq(11'h000, 11'h000);
        share <= 1'b0;
        chk_irq(11'h000, 11'h400);
        io_write(BASE + 16'h5, 8'h30);
        pulse(1'b0);
        chk_irq(11'h400, 11'h400);
        // end of interrupt: 0x38 to channel A control clears the
        // serial model's scc_irq, so the line itself must drop here.
        io_write(BASE + 16'h1, 8'h38);
        chk_irq(11'h000, 11'h400);
        share <= 1'b1;
        pulse(1'b0);
        chk_irq(11'h400, 11'h400);
        io_write(BASE + 16'h1, 8'h38);
        chk_irq(11'h000, 11'h000);
        io_write(BASE + 16'h5, 8'h10);
        pulse(1'b1);
        chk_irq(11'h400, 11'h400);
        io_write(BASE + 16'h5, 8'h10);
        chk_irq(11'h000, 11'h000);
        share <= 1'b0;
        pulse(1'b1);
        chk_irq(11'h000, 11'h400);
        close_out();
    end
endmodule : tb_isa_card_decode_irq_glue
`default_nettype wire
